// File: hw/mpwm_defs.svh
// Register offsets, field positions and sizes of the PWM timer
`ifndef MPWM_DEFS_SVH
`define MPWM_DEFS_SVH
`define MPWM_AW       7
`define MPWM_NMR      7
`define MPWM_NCAP     4
`define MPWM_NEM      4
`define MPWM_NPWM     6
// Byte offsets
`define MPWM_A_IR     7'h00
`define MPWM_A_TCR    7'h04
`define MPWM_A_TC     7'h08
`define MPWM_A_PR     7'h0c
`define MPWM_A_PC     7'h10
`define MPWM_A_MCR    7'h14
`define MPWM_A_CCR    7'h18
`define MPWM_A_MR0    7'h1c
`define MPWM_A_CR0    7'h38
`define MPWM_A_CTCR   7'h48
`define MPWM_A_PCR    7'h4c
`define MPWM_A_LER    7'h50
`define MPWM_A_EMR    7'h54
`define MPWM_A_MSK    7'h58
`define MPWM_A_OUT    7'h5c
// Control fields
`define MPWM_TCR_EN   0
`define MPWM_TCR_RST  1
`define MPWM_TCR_PWM  3
`define MPWM_MCR_INT  0
`define MPWM_MCR_RST  1
`define MPWM_MCR_STP  2
`define MPWM_CCR_RISE 0
`define MPWM_CCR_FALL 1
`define MPWM_CCR_INT  2
`define MPWM_IR_CAP   7
`define MPWM_IR_W     11
`define MPWM_PCR_ENA  9
`define MPWM_PCR_W    15
`define MPWM_EMR_ACT  4
`define MPWM_ZERO32   32'h0000_0000
`define MPWM_ONE32    32'h0000_0001
`endif

// File: hw/mpwm_pkg.sv
// Types shared by the PWM timer
`default_nettype none
package mpwm_pkg;
  typedef enum logic [1:0] {
    MPWM_EM_NOP  = 2'b00,
    MPWM_EM_LOW  = 2'b01,
    MPWM_EM_HIGH = 2'b10,
    MPWM_EM_TOG  = 2'b11
  } mpwm_emact_e;
  typedef enum logic [1:0] {
    MPWM_CNT_TIMER = 2'b00,
    MPWM_CNT_RISE  = 2'b01,
    MPWM_CNT_FALL  = 2'b10,
    MPWM_CNT_BOTH  = 2'b11
  } mpwm_cnt_e;
endpackage
`default_nettype wire

// File: hw/mpwm_timer.sv
// Match-based PWM timer/counter with capture, match outputs, interrupt
//
// How it works
// - 32-bit counter steps once per prescaler terminal count.
// - Counts clock cycles, or edges of a selected capture input.
// - Seven match registers feed up to six PWM outputs.
// - Per match: optional flag, stop counter, reset counter.
// - In PWM mode, period match resets the count.
// - Single-edge outputs go high on period match unless cleared.
// - Single-edge output falls on its own match register.
// - Double-edge output rises on one match, falls on next.
// - Rise before fall gives positive pulse, else negative.
// - All outputs share the period set by match zero.
// - Period and width are any whole number of counts.
// - In PWM mode match writes are shadowed; applied at cycle start after release.
// - Without PWM mode, plain timer with match and capture.
// - Configured capture edge copies count, may raise a flag.
// - Match outputs go low, high, toggle or hold on match.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`include "mpwm_defs.svh"
`default_nettype none
module mpwm_timer (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [`MPWM_AW-1:0]   i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [`MPWM_NCAP-1:0] i_cap,
  output logic      [31:0]           o_rdata,
  output logic      [`MPWM_NPWM:1]   o_pwm,
  output logic      [`MPWM_NEM-1:0]  o_em,
  output logic                       o_irq
);
  localparam int NMR = `MPWM_NMR;
  localparam int NCP = `MPWM_NCAP;

  logic [31:0]             tc_q, pr_q, pc_q;
  logic [`MPWM_TCR_PWM:0]  tcr_q;
  logic [3*NMR-1:0]        mcr_q;
  logic [3*NCP-1:0]        ccr_q;
  logic [3:0]              ctcr_q;
  logic [`MPWM_PCR_W-1:0]  pcr_q;
  logic [NMR-1:0]          ler_q;
  logic [`MPWM_IR_W-1:0]   ir_q, msk_q, ir_d;
  logic [NCP-1:0]          s1_q, s2_q, s3_q;
  logic [`MPWM_NPWM:1]     pwm_q, pwm_d;
  logic [2*`MPWM_NEM-1:0]  act_q;
  logic [31:0]             sh_q [NMR];
  logic [31:0]             mr_q [NMR];
  logic [31:0]             cr_q [NCP];

  // Register map, byte offsets; narrow fields sit in the low bits
  //   0x00 status, write one to clear
  //        bits 6:0 match 0..6, bits 10:7 capture 0..3
  //   0x04 run control
  //        bit 0 enable, bit 1 hold counters at zero, bit 3 pulse mode
  //   0x08 count, writable
  //   0x0c prescale limit
  //   0x10 prescale count, read only
  //   0x14 match control, three bits per match from bit 3*i
  //        flag, reset on match, stop on match
  //   0x18 capture control, three bits per input from bit 3*j
  //        rising edge, falling edge, flag
  //   0x1c + 4*i match i, reads back the shadow copy
  //   0x38 + 4*j capture j, read only
  //   0x48 count source
  //        bits 1:0 timer, rising, falling or both edges
  //        bits 3:2 input that clocks the count
  //   0x4c pulse control
  //        bits 6:2 double edge for outputs 2..6
  //        bits 14:9 enable for outputs 1..6
  //   0x50 release, write one per match; cleared on transfer
  //   0x54 match outputs
  //        bits 3:0 levels, bits 4+2k action of output k
  //   0x58 interrupt mask, status layout
  //   0x5c pulse output readback in bits 6:1
  //
  // Timing notes
  //   A prescale limit of L gives L+1 ticks per count.
  //   A match hits on the step that leaves its value.
  //   Outputs, flags and match pins move on the same edge as the count.
  //   Pulse period is the period match plus one count.
  //   Single edge: set on period match, cleared by its own match.
  //   Double edge: set by the match below, cleared by its own.
  //   Clear wins when both fall on one step, giving a constant low.
  //   Shadow values go live only on a period match after release,
  //   so no cycle ever sees half of an update.
  //   Outside pulse mode a match write goes live at once.
  //   Capture edges show about three clocks after the pin moves,
  //   the price of the synchroniser; very short pin pulses are lost.
  //   Count-source edges count once each; both-edge mode counts twice.
  //   Writes win over a same-cycle stop or transfer.
  //   Flag set wins over a same-cycle clear.
  //   Interrupt lags a mask change by one clock.
  //   Unmapped reads return zero; unmapped writes are dropped.

  // Address decode
  wire a_ir   = i_addr == `MPWM_A_IR;
  wire a_tcr  = i_addr == `MPWM_A_TCR;
  wire a_tc   = i_addr == `MPWM_A_TC;
  wire a_pr   = i_addr == `MPWM_A_PR;
  wire a_pc   = i_addr == `MPWM_A_PC;
  wire a_mcr  = i_addr == `MPWM_A_MCR;
  wire a_ccr  = i_addr == `MPWM_A_CCR;
  wire a_ctcr = i_addr == `MPWM_A_CTCR;
  wire a_pcr  = i_addr == `MPWM_A_PCR;
  wire a_ler  = i_addr == `MPWM_A_LER;
  wire a_emr  = i_addr == `MPWM_A_EMR;
  wire a_msk  = i_addr == `MPWM_A_MSK;
  wire a_out  = i_addr == `MPWM_A_OUT;
  logic [NMR-1:0] a_mr;
  logic [NCP-1:0] a_cr;

  // Control bits
  wire en      = tcr_q[`MPWM_TCR_EN];
  wire crst    = tcr_q[`MPWM_TCR_RST];
  wire pwm_en  = tcr_q[`MPWM_TCR_PWM];
  wire [1:0] cmode = ctcr_q[1:0];
  wire [1:0] csel  = ctcr_q[3:2];

  // Capture edges, taken from second and third sync stages only
  wire [NCP-1:0] rise = s2_q & ~s3_q;
  wire [NCP-1:0] fall = ~s2_q & s3_q;
  wire cnt_edge = (cmode[0] & rise[csel]) | (cmode[1] & fall[csel]);
  wire timer_md = cmode == mpwm_pkg::MPWM_CNT_TIMER;
  wire tick = en & ~crst & (timer_md | cnt_edge);
  wire step = tick & (pc_q == pr_q);

  // Match and capture events
  logic [NMR-1:0] hit, m_int, m_rst, m_stp;
  logic [NCP-1:0] cap_ev, c_int;
  wire rst_hit = |(hit & m_rst) | (pwm_en & hit[0]);
  wire stp_hit = |(hit & m_stp);
  wire cyc     = pwm_en & hit[0];

  genvar gi;
  generate
    for (gi = 0; gi < NMR; gi++) begin : g_mr
      assign a_mr[gi]  = i_addr == `MPWM_AW'(`MPWM_A_MR0 + 4 * gi);
      assign hit[gi]   = step & (tc_q == mr_q[gi]);
      assign m_int[gi] = mcr_q[3*gi+`MPWM_MCR_INT];
      assign m_rst[gi] = mcr_q[3*gi+`MPWM_MCR_RST];
      assign m_stp[gi] = mcr_q[3*gi+`MPWM_MCR_STP];
      wire wr_mr = i_wr & a_mr[gi];
      wire load  = cyc & ler_q[gi];
      // Shadow always takes writes; live copy at cycle start, or at once outside pulse mode
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          sh_q[gi] <= `MPWM_ZERO32;
          mr_q[gi] <= `MPWM_ZERO32;
        end else begin
          if (wr_mr) begin
            sh_q[gi] <= i_wdata;
          end
          if (!pwm_en && wr_mr) begin
            mr_q[gi] <= i_wdata;
          end else if (load) begin
            mr_q[gi] <= sh_q[gi];
          end
        end
      end
      // Release bit: software sets, cycle start consumes
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          ler_q[gi] <= 1'b0;
        end else if (i_wr && a_ler && i_wdata[gi]) begin
          ler_q[gi] <= 1'b1;
        end else if (load) begin
          ler_q[gi] <= 1'b0;
        end
      end
    end

    for (gi = 0; gi < NCP; gi++) begin : g_cap
      assign a_cr[gi]   = i_addr == `MPWM_AW'(`MPWM_A_CR0 + 4 * gi);
      assign c_int[gi]  = ccr_q[3*gi+`MPWM_CCR_INT];
      assign cap_ev[gi] =
        (ccr_q[3*gi+`MPWM_CCR_RISE] & rise[gi]) |
        (ccr_q[3*gi+`MPWM_CCR_FALL] & fall[gi]);
      // Snapshot of the count on the chosen edge
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          cr_q[gi] <= `MPWM_ZERO32;
        end else if (cap_ev[gi]) begin
          cr_q[gi] <= tc_q;
        end
      end
    end

    // Edge logic per PWM output; clear beats set so a zero width
    // gives a constant low
    for (gi = 1; gi <= `MPWM_NPWM; gi++) begin : g_pwm
      wire dbl = (gi >= 2) ? pcr_q[gi] : 1'b0;
      wire set = dbl ? hit[gi-1] : hit[0];
      wire clr = hit[gi];
      assign pwm_d[gi] = !pwm_en ? 1'b0 :
                         clr ? 1'b0 : set ? 1'b1 : pwm_q[gi];
    end

    // Match output actions
    for (gi = 0; gi < `MPWM_NEM; gi++) begin : g_em
      mpwm_pkg::mpwm_emact_e act;
      assign act = mpwm_pkg::mpwm_emact_e'(act_q[2*gi +: 2]);
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          o_em[gi] <= 1'b0;
        end else if (i_wr && a_emr) begin
          o_em[gi] <= i_wdata[gi];
        end else if (hit[gi]) begin
          unique case (act)
            mpwm_pkg::MPWM_EM_NOP:  o_em[gi] <= o_em[gi];
            mpwm_pkg::MPWM_EM_LOW:  o_em[gi] <= 1'b0;
            mpwm_pkg::MPWM_EM_HIGH: o_em[gi] <= 1'b1;
            mpwm_pkg::MPWM_EM_TOG:  o_em[gi] <= ~o_em[gi];
          endcase
        end
      end
    end
  endgenerate

  // Read selection over the indexed banks
  logic [31:0] mr_or [NMR+1];
  logic [31:0] cr_or [NCP+1];
  assign mr_or[0] = `MPWM_ZERO32;
  assign cr_or[0] = `MPWM_ZERO32;
  generate
    for (gi = 0; gi < NMR; gi++) begin : g_rmr
      assign mr_or[gi+1] = mr_or[gi] | ({32{a_mr[gi]}} & sh_q[gi]);
    end
    for (gi = 0; gi < NCP; gi++) begin : g_rcr
      assign cr_or[gi+1] = cr_or[gi] | ({32{a_cr[gi]}} & cr_q[gi]);
    end
  endgenerate

  // Unmapped addresses read zero
  wire [31:0] rd_mux =
    a_ir   ? 32'(ir_q)   :
    a_tcr  ? 32'(tcr_q)  :
    a_tc   ? tc_q        :
    a_pr   ? pr_q        :
    a_pc   ? pc_q        :
    a_mcr  ? 32'(mcr_q)  :
    a_ccr  ? 32'(ccr_q)  :
    a_ctcr ? 32'(ctcr_q) :
    a_pcr  ? 32'(pcr_q)  :
    a_ler  ? 32'(ler_q)  :
    a_emr  ? 32'({act_q, o_em}) :
    a_msk  ? 32'(msk_q)  :
    a_out  ? 32'({o_pwm, 1'b0}) :
    (mr_or[NMR] | cr_or[NCP]);

  // Sticky flags: a new event wins over a same-cycle clear
  wire [`MPWM_IR_W-1:0] ir_set = {cap_ev & c_int, hit & m_int};
  wire [`MPWM_IR_W-1:0] ir_clr =
    (i_wr && a_ir) ? i_wdata[`MPWM_IR_W-1:0] : '0;
  assign ir_d = (ir_q & ~ir_clr) | ir_set;

  // Count chain; reset bit holds both counters at zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tc_q <= `MPWM_ZERO32;
      pc_q <= `MPWM_ZERO32;
    end else if (crst) begin
      tc_q <= `MPWM_ZERO32;
      pc_q <= `MPWM_ZERO32;
    end else if (i_wr && a_tc) begin
      tc_q <= i_wdata;
    end else if (step) begin
      pc_q <= `MPWM_ZERO32;
      tc_q <= rst_hit ? `MPWM_ZERO32 : tc_q + `MPWM_ONE32;
    end else if (tick) begin
      pc_q <= pc_q + `MPWM_ONE32;
    end
  end

  // Run control; a stop match drops the enable
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tcr_q <= '0;
    end else if (i_wr && a_tcr) begin
      // Bit 2 is unused and reads zero
      tcr_q <= {i_wdata[`MPWM_TCR_PWM], 1'b0,
                i_wdata[`MPWM_TCR_RST:`MPWM_TCR_EN]};
    end else if (stp_hit) begin
      tcr_q[`MPWM_TCR_EN] <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pr_q   <= `MPWM_ZERO32;
      mcr_q  <= '0;
      ccr_q  <= '0;
      ctcr_q <= 4'h0;
      pcr_q  <= '0;
      act_q  <= '0;
      msk_q  <= '0;
    end else if (i_wr) begin
      if (a_pr)   pr_q   <= i_wdata;
      if (a_mcr)  mcr_q  <= i_wdata[3*NMR-1:0];
      if (a_ccr)  ccr_q  <= i_wdata[3*NCP-1:0];
      if (a_ctcr) ctcr_q <= i_wdata[3:0];
      if (a_pcr)  pcr_q  <= i_wdata[`MPWM_PCR_W-1:0];
      if (a_emr)  act_q  <= i_wdata[`MPWM_EMR_ACT +: 2*`MPWM_NEM];
      if (a_msk)  msk_q  <= i_wdata[`MPWM_IR_W-1:0];
    end
  end

  // Capture pins cross into the clock domain through three stages
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_cap;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Registered outputs; pins masked by their enables
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ir_q    <= '0;
      pwm_q   <= '0;
      o_pwm   <= '0;
      o_irq   <= 1'b0;
      o_rdata <= `MPWM_ZERO32;
    end else begin
      ir_q    <= ir_d;
      pwm_q   <= pwm_d;
      o_pwm   <= pwm_d & pcr_q[`MPWM_PCR_ENA +: `MPWM_NPWM];
      o_irq   <= |(ir_d & msk_q);
      o_rdata <= i_rd ? rd_mux : `MPWM_ZERO32;
    end
  end
endmodule
`default_nettype wire

// File: tb/mpwm_properties.sv
// Port-level assertions for the PWM timer
`include "mpwm_defs.svh"
`default_nettype none
module mpwm_properties (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [6:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [3:0]  i_cap,
  input wire logic [31:0] o_rdata,
  input wire logic [6:1]  o_pwm,
  input wire logic [3:0]  o_em,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus decodes; a mask write may drop the request a cycle late
  wire w_tcr = i_wr && i_addr == `MPWM_A_TCR;
  wire w_clr = i_wr && (i_addr == `MPWM_A_IR || i_addr == `MPWM_A_MSK);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_pr_wr; i_wr && i_addr == `MPWM_A_PR; endsequence
  sequence s_pr_rd; i_rd && i_addr == `MPWM_A_PR; endsequence
  sequence s_pwm_off; w_tcr && !i_wdata[`MPWM_TCR_PWM]; endsequence
  a_reset_quiet: assert property (
    $rose(i_rst_n) |-> o_pwm == 6'h00 && o_em == 4'h0 && !o_irq)
    else $error("outputs busy after reset");
  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0) else $error("read data without read");
  a_unmapped_rd: assert property (
    i_rd && i_addr > 7'h5c |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_out_mirror: assert property (
    i_rd && i_addr == `MPWM_A_OUT |=> o_rdata == {25'h0, $past(o_pwm), 1'b0})
    else $error("output readback differs from pins");
  a_narrow_rd: assert property (
    i_rd && i_addr == `MPWM_A_LER |=> o_rdata[31:7] == 25'h0)
    else $error("release readback upper bits set");
  a_pr_readback: assert property (
    s_pr_wr ##1 s_pr_rd |=> o_rdata == $past(i_wdata, 2))
    else $error("prescale limit readback wrong");
  a_pwm_off: assert property (
    s_pwm_off ##1 !w_tcr [*3] |-> o_pwm == 6'h00)
    else $error("pulse output outside pulse mode");
  a_irq_sticky: assert property (
    o_irq && !w_clr && !$past(w_clr) |=> o_irq)
    else $error("interrupt dropped without clear");
endmodule
`default_nettype wire

// File: tb/mpwm_pins_model.sv
// Outside source driving the capture and count pins
`default_nettype none
module mpwm_pins_model #(
  parameter int HOLD = 6
) (
  input  wire logic       i_clk,
  output var  logic [3:0] o_cap
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_cap = 4'h0;
  // Slow pulse: each level holds HOLD clocks, longer than the one clock the pin synchroniser needs
  task automatic pulse(input int pin);
    @(posedge i_clk);
    o_cap[pin] <= 1'b1;
    repeat (HOLD) @(posedge i_clk);
    o_cap[pin] <= 1'b0;
    repeat (HOLD) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the PWM timer
`include "mpwm_defs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, o_irq;
  logic        i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [6:0]  i_addr = 7'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0]  i_cap, o_em;
  logic [6:1]  o_pwm;
  int          err_total = 0, checked = 0, cyc_n = 0;
  int          hc [0:6];
  int          mv [0:5] = '{9, 3, 2, 6, 7, 2};
  int          ex [0:6] = '{10, 8, 0, 8, 0, 10, 0};
  mpwm_timer u_mpwm_timer (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .i_cap, .o_rdata, .o_pwm, .o_em, .o_irq);
  mpwm_pins_model #(.HOLD(6)) u_mpwm_pins_model (.i_clk, .o_cap(i_cap));
  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus cycle, launched just after a rising edge
  task automatic cyc(input logic w, r, input logic [6:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, a, d);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    cyc(1'b0, 1'b1, a, 32'h0);
    cyc(1'b0, 1'b0, a, 32'h0);
    #1;
    chk($sformatf("reg %h", a), e, o_rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 7'h00, 32'h0);
  endtask
  task automatic irq(input logic e);
    idle(2);
    #1;
    chk("irq", {31'h0, e}, {31'h0, o_irq});
  endtask
  // High-time census of match output 0 and every pulse output over n cycles
  task automatic meas(input int n);
    hc = '{default: 0};
    repeat (n) begin
      @(posedge i_clk);
      #1;
      hc[0] += int'(o_em[0]);
      for (int k = 1; k <= 6; k++) hc[k] += int'(o_pwm[k]);
    end
  endtask
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard; the run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      err_total++;
      test_done();
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`MPWM_A_TC, 32'h0);
    rd(7'h60, 32'h0);
    cyc(1'b1, 1'b0, `MPWM_A_PR, 32'h2);
    rd(`MPWM_A_PR, 32'h2);
    // Stop on match, three ticks per count
    wr(`MPWM_A_MR0, 32'h5);
    wr(`MPWM_A_MCR, 32'h5);
    wr(`MPWM_A_MSK, 32'h1);
    wr(`MPWM_A_TCR, 32'h1);
    idle(40);
    rd(`MPWM_A_TC, 32'h6);
    rd(`MPWM_A_TCR, 32'h0);
    rd(`MPWM_A_IR, 32'h1);
    irq(1'b1);
    wr(`MPWM_A_MSK, 32'h0);
    irq(1'b0);
    wr(`MPWM_A_IR, 32'h1);
    rd(`MPWM_A_IR, 32'h0);
    // Period of ten counts: one single, one positive, one negative pulse
    wr(`MPWM_A_TCR, 32'h2);
    wr(`MPWM_A_MCR, 32'h0);
    wr(`MPWM_A_PR, 32'h0);
    for (int i = 0; i < 6; i++) wr(7'(`MPWM_A_MR0 + 4 * i), mv[i]);
    wr(`MPWM_A_EMR, 32'h1bc);
    wr(`MPWM_A_PCR, 32'h2a28);
    wr(`MPWM_A_TCR, 32'h9);
    idle(25);
    meas(20);
    for (int k = 0; k <= 6; k++) chk("high", ex[k], hc[k]);
    chk("em", 32'h5, {29'h0, o_em[3:1]});
    // New width waits for its release
    wr(7'(`MPWM_A_MR0 + 4), 32'h6);
    meas(20);
    chk("held", 32'd8, hc[1]);
    wr(`MPWM_A_LER, 32'h2);
    idle(12);
    rd(`MPWM_A_LER, 32'h0);
    meas(20);
    chk("width", 32'd14, hc[1]);
    // Stop on match two freezes the pins mid-cycle
    wr(`MPWM_A_MCR, 32'h100);
    idle(12);
    rd(`MPWM_A_TC, 32'h3);
    rd(`MPWM_A_OUT, 32'h0a);
    wr(`MPWM_A_MCR, 32'h0);
    // Pin 1 clocks the count in each edge mode, pin 0 captures
    wr(`MPWM_A_MSK, 32'h80);
    for (int m = 1; m <= 3; m++) begin
      wr(`MPWM_A_CCR, m == 2 ? 32'h6 : 32'h5);
      wr(`MPWM_A_TCR, 32'h2);
      wr(`MPWM_A_CTCR, 32'(m + 4));
      wr(`MPWM_A_TCR, 32'h1);
      repeat (3) u_mpwm_pins_model.pulse(1);
      u_mpwm_pins_model.pulse(0);
      rd(`MPWM_A_TC, m == 3 ? 32'h6 : 32'h3);
      rd(`MPWM_A_CR0, m == 3 ? 32'h6 : 32'h3);
      irq(1'b1);
      wr(`MPWM_A_IR, 32'h80);
    end
    test_done();
  end
endmodule
bind mpwm_timer mpwm_properties u_mpwm_properties (.i_clk, .i_rst_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .i_cap, .o_rdata, .o_pwm, .o_em, .o_irq);
`default_nettype wire
